// [logic/cirq_defs.vh]
// offsets, field positions, reset values and mode codes of the can event block
`ifndef CIRQ_DEFS_VH
`define CIRQ_DEFS_VH

// ==========================================================
// register byte offsets
`define CIRQ_OFS_PIN_CTRL 8'h00
`define CIRQ_OFS_FLAGS 8'h04
`define CIRQ_OFS_ENABLES 8'h08
`define CIRQ_OFS_PRIOS 8'h0C
`define CIRQ_OFS_TXB_EN 8'h10
`define CIRQ_OFS_BUF_EN 8'h14
`define CIRQ_OFS_MODE 8'h18

// ==========================================================
// field positions
`define CIRQ_BIT_DRIVE_HIGH 5
`define CIRQ_BIT_RX_CAPTURE 4
`define CIRQ_BIT_INVALID 7
`define CIRQ_BIT_WAKE 6
`define CIRQ_BIT_ERROR 5
`define CIRQ_BIT_TX_GROUP 4
`define CIRQ_BIT_TX1 3
`define CIRQ_BIT_TX0 2
`define CIRQ_BIT_RX_GROUP 1
`define CIRQ_BIT_LOW 0

// ==========================================================
// reset values and implemented-bit masks
`define CIRQ_RST_ZERO 8'h00
`define CIRQ_RST_PRIOS 8'hFF
`define CIRQ_RST_MODE 2'h0
`define CIRQ_MASK_PIN_CTRL 8'h30
`define CIRQ_MASK_TXB_EN 8'h1C
`define CIRQ_MASK_MODE0 8'hFF
`define CIRQ_MASK_MODE1 8'hF2
`define CIRQ_MASK_MODE2 8'hF3

// ==========================================================
// operating modes and bus answers
`define CIRQ_MODE_0 2'h0
`define CIRQ_MODE_1 2'h1
`define CIRQ_RESP_OKAY 2'h0
`define CIRQ_RESP_SLVERR 2'h2

`endif

// [logic/cirq_sync.v]
// three-stage synchroniser with agreement filter for a pin level
`default_nettype none

module cirq_sync
(
  // clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  // pin side
  input wire pin_in,
  // clock domain side
  output reg level_out
);

  reg stage1_reg;
  reg stage2_reg;
  reg stage3_reg;

  // ==========================================================
  // stages; only stage2 looks at stage1
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      // a change counts only once two stages agree
      if (stage2_reg == stage3_reg)
        level_out <= stage3_reg;
    end
  end

endmodule // cirq_sync

`default_nettype wire

// [logic/cirq_top.v]
// can event flags, enables, priorities and pin control behind an axi4-lite slave
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`default_nettype none
`include "cirq_defs.vh"

// Notes on behaviour
// - drive-high set: transmit pin driven high when recessive, else released.
// - capture enable routes can receive signal to capture unit instead of pin.
// - invalid message on bus sets flag bit 7.
// - bus activity sets wake flag bit 6.
// - any of several module error sources sets flag bit 5.
// - mode 0: transmit buffer 2 completion sets flag bit 4.
// - modes 1 and 2: any transmit completion sets flag bit 4.
// - mode 0: transmit buffers 1 and 0 set flag bits 3 and 2.
// - modes 1 and 2: bits 3 and 2 of flags, enables, priorities read zero.
// - mode 0: receive buffers 1 and 0 set flag bits 1 and 0.
// - modes 1 and 2: any receive buffer arrival sets flag bit 1.
// - mode 2: fifo watermark sets bit 0; mode 1: bit 0 reads zero.
// - each flag has an enable at same position; enables reset to zero.
// - modes 1 and 2: enable bit 4 is transmit master, buffers gated individually.
// - modes 1 and 2: enable bit 1 is receive master, buffers gated individually.
// - cleared group master blocks all that group's buffer interrupts.
// - each flag has a priority bit, 1 high, 0 low; reset to ones.
// - transmit-buffer enable register holds buffers 2..0 in bits 4..2, rest zero.
// - transmit-buffer enables exist only in modes 1 and 2, need master set.
// - per-buffer enables: programmable 7..2, dedicated receive 1..0, modes 1,2 only.
module cirq_top #(
  parameter ADDR_W = 8,
  parameter ERR_SRC_W = 4
)
(
  // clock and reset
  input wire sys_clk_in,
  input wire rst_in,
  // axi4-lite write address and data
  input wire [ADDR_W-1:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  // axi4-lite read
  input wire [ADDR_W-1:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // events from the can engine, one-cycle pulses
  input wire invalid_msg_evt_in,
  input wire bus_wake_evt_in,
  input wire [ERR_SRC_W-1:0] module_err_evt_in,
  input wire [2:0] tx_buf_done_evt_in,
  input wire [5:0] prog_tx_done_evt_in,
  input wire [5:0] prog_rx_full_evt_in,
  input wire [1:0] rx_buf_full_evt_in,
  input wire fifo_watermark_evt_in,
  // transmit and receive signals of the engine
  input wire tx_bit_in,
  input wire rx_msg_signal_in,
  // pins and capture routing
  output reg can_transmit_pin_out,
  output reg can_transmit_pin_oe_out,
  input wire capture_input_pin_in,
  output reg capture_unit_in_out,
  // interrupt lines and current mode
  output reg irq_high_out,
  output reg irq_low_out,
  output reg [1:0] mode_out
);

  // ==========================================================
  // helpers
  function [7:0] mode_mask;
    input [1:0] mode;
    begin
      if (mode == `CIRQ_MODE_0)
        mode_mask = `CIRQ_MASK_MODE0;
      else if (mode == `CIRQ_MODE_1)
        mode_mask = `CIRQ_MASK_MODE1;
      else
        mode_mask = `CIRQ_MASK_MODE2;
    end
  endfunction

  function addr_hit;
    input [ADDR_W-1:0] addr;
    input [7:0] offset;
    begin
      addr_hit = (addr == offset[ADDR_W-1:0]);
    end
  endfunction

  // ==========================================================
  // registers
  reg [7:0] pin_ctrl_reg;
  reg [7:0] flags_reg;
  reg [7:0] enables_reg;
  reg [7:0] prios_reg;
  reg [7:0] txb_en_reg;
  reg [7:0] buf_en_reg;
  reg [1:0] mode_reg;
  reg [2:0] tx_pend_reg;
  reg [5:0] ptx_pend_reg;
  reg [5:0] prx_pend_reg;
  reg [1:0] rxd_pend_reg;

  reg [7:0] flags_next;
  reg [7:0] set_vec;
  reg [7:0] req_vec;
  reg [31:0] rdata_next;
  reg rd_ok;

  wire capture_pin_level;
  wire [7:0] mask;
  wire mode0;
  wire mode2;
  wire wr_fire;
  wire rd_fire;
  wire wr_lane0;
  wire wr_flags;
  wire [7:0] wbyte;
  wire wr_ok;
  wire tx_gate;
  wire rx_gate;

  assign mask = mode_mask(mode_reg);
  assign mode0 = (mode_reg == `CIRQ_MODE_0);
  assign mode2 = ~mode0 && (mode_reg != `CIRQ_MODE_1);
  assign wbyte = s_axi_wdata_in[7:0];

  // ==========================================================
  // capture pin synchroniser
  cirq_sync u_cap_sync
  (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .pin_in(capture_input_pin_in),
    .level_out(capture_pin_level)
  );

  // ==========================================================
  // axi4-lite handshakes
  // ready pulses one cycle once both address and data wait, so the
  // pair is always taken together and no skid buffer is needed
  assign wr_fire = s_axi_awready_out & s_axi_awvalid_in & s_axi_wvalid_in;
  assign rd_fire = s_axi_arready_out & s_axi_arvalid_in;
  assign wr_lane0 = wr_fire & s_axi_wstrb_in[0];
  assign wr_ok = addr_hit(s_axi_awaddr_in, `CIRQ_OFS_PIN_CTRL)
    | addr_hit(s_axi_awaddr_in, `CIRQ_OFS_FLAGS)
    | addr_hit(s_axi_awaddr_in, `CIRQ_OFS_ENABLES)
    | addr_hit(s_axi_awaddr_in, `CIRQ_OFS_PRIOS)
    | addr_hit(s_axi_awaddr_in, `CIRQ_OFS_TXB_EN)
    | addr_hit(s_axi_awaddr_in, `CIRQ_OFS_BUF_EN)
    | addr_hit(s_axi_awaddr_in, `CIRQ_OFS_MODE);
  assign wr_flags = wr_lane0 & addr_hit(s_axi_awaddr_in, `CIRQ_OFS_FLAGS);

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `CIRQ_RESP_OKAY;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rresp_out <= `CIRQ_RESP_OKAY;
      s_axi_rdata_out <= 32'h0000_0000;
    end
    else
    begin
      s_axi_awready_out <= ~s_axi_awready_out & s_axi_awvalid_in & s_axi_wvalid_in
        & ~s_axi_bvalid_out;
      s_axi_wready_out <= ~s_axi_awready_out & s_axi_awvalid_in & s_axi_wvalid_in
        & ~s_axi_bvalid_out;
      if (wr_fire)
      begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_ok ? `CIRQ_RESP_OKAY : `CIRQ_RESP_SLVERR;
      end
      else if (s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
      s_axi_arready_out <= ~s_axi_arready_out & s_axi_arvalid_in & ~s_axi_rvalid_out;
      if (rd_fire)
      begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rdata_next;
        s_axi_rresp_out <= rd_ok ? `CIRQ_RESP_OKAY : `CIRQ_RESP_SLVERR;
      end
      else if (s_axi_rready_in)
        s_axi_rvalid_out <= 1'b0;
    end
  end

  // ==========================================================
  // read mux; forced and absent bits read as zero
  always @*
  begin
    rdata_next = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr_in)
      `CIRQ_OFS_PIN_CTRL:
        rdata_next[7:0] = pin_ctrl_reg & `CIRQ_MASK_PIN_CTRL;
      `CIRQ_OFS_FLAGS:
        rdata_next[7:0] = flags_reg & mask;
      `CIRQ_OFS_ENABLES:
        rdata_next[7:0] = enables_reg & mask;
      `CIRQ_OFS_PRIOS:
        rdata_next[7:0] = prios_reg & mask;
      `CIRQ_OFS_TXB_EN:
        rdata_next[7:0] = mode0 ? 8'h00 : (txb_en_reg & `CIRQ_MASK_TXB_EN);
      `CIRQ_OFS_BUF_EN:
        rdata_next[7:0] = mode0 ? 8'h00 : buf_en_reg;
      `CIRQ_OFS_MODE:
        rdata_next[1:0] = mode_reg;
      default:
        rd_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // configuration registers
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_ctrl_reg <= `CIRQ_RST_ZERO;
      enables_reg <= `CIRQ_RST_ZERO;
      prios_reg <= `CIRQ_RST_PRIOS;
      txb_en_reg <= `CIRQ_RST_ZERO;
      buf_en_reg <= `CIRQ_RST_ZERO;
      mode_reg <= `CIRQ_RST_MODE;
    end
    else if (wr_lane0)
    begin
      if (addr_hit(s_axi_awaddr_in, `CIRQ_OFS_PIN_CTRL))
        pin_ctrl_reg <= wbyte & `CIRQ_MASK_PIN_CTRL;
      if (addr_hit(s_axi_awaddr_in, `CIRQ_OFS_ENABLES))
        enables_reg <= wbyte;
      if (addr_hit(s_axi_awaddr_in, `CIRQ_OFS_PRIOS))
        prios_reg <= wbyte;
      // both buffer enable registers are absent in mode 0
      if (addr_hit(s_axi_awaddr_in, `CIRQ_OFS_TXB_EN) && !mode0)
        txb_en_reg <= wbyte & `CIRQ_MASK_TXB_EN;
      if (addr_hit(s_axi_awaddr_in, `CIRQ_OFS_BUF_EN) && !mode0)
        buf_en_reg <= wbyte;
      if (addr_hit(s_axi_awaddr_in, `CIRQ_OFS_MODE))
        mode_reg <= wbyte[1:0];
    end
  end

  // ==========================================================
  // event flags; a hardware set wins over a software clear
  always @*
  begin
    set_vec = 8'h00;
    set_vec[`CIRQ_BIT_INVALID] = invalid_msg_evt_in;
    set_vec[`CIRQ_BIT_WAKE] = bus_wake_evt_in;
    set_vec[`CIRQ_BIT_ERROR] = |module_err_evt_in;
    if (mode0)
    begin
      set_vec[`CIRQ_BIT_TX_GROUP] = tx_buf_done_evt_in[2];
      set_vec[`CIRQ_BIT_TX1] = tx_buf_done_evt_in[1];
      set_vec[`CIRQ_BIT_TX0] = tx_buf_done_evt_in[0];
      set_vec[`CIRQ_BIT_RX_GROUP] = rx_buf_full_evt_in[1];
      set_vec[`CIRQ_BIT_LOW] = rx_buf_full_evt_in[0];
    end
    else
    begin
      set_vec[`CIRQ_BIT_TX_GROUP] = |tx_buf_done_evt_in | |prog_tx_done_evt_in;
      set_vec[`CIRQ_BIT_RX_GROUP] = |rx_buf_full_evt_in | |prog_rx_full_evt_in;
      set_vec[`CIRQ_BIT_LOW] = mode2 & fifo_watermark_evt_in;
    end
    flags_next = ((wr_flags ? wbyte : flags_reg) | set_vec) & mask;
  end

  // ==========================================================
  // per-buffer pending state behind the group flags
  // cleared together with its group flag, so a stale buffer cannot
  // keep the group request alive after software acknowledged it
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      flags_reg <= `CIRQ_RST_ZERO;
      tx_pend_reg <= 3'h0;
      ptx_pend_reg <= 6'h00;
      prx_pend_reg <= 6'h00;
      rxd_pend_reg <= 2'h0;
    end
    else
    begin
      flags_reg <= flags_next;
      if (wr_flags && !wbyte[`CIRQ_BIT_TX_GROUP])
      begin
        tx_pend_reg <= tx_buf_done_evt_in;
        ptx_pend_reg <= prog_tx_done_evt_in;
      end
      else
      begin
        tx_pend_reg <= tx_pend_reg | tx_buf_done_evt_in;
        ptx_pend_reg <= ptx_pend_reg | prog_tx_done_evt_in;
      end
      if (wr_flags && !wbyte[`CIRQ_BIT_RX_GROUP])
      begin
        prx_pend_reg <= prog_rx_full_evt_in;
        rxd_pend_reg <= rx_buf_full_evt_in;
      end
      else
      begin
        prx_pend_reg <= prx_pend_reg | prog_rx_full_evt_in;
        rxd_pend_reg <= rxd_pend_reg | rx_buf_full_evt_in;
      end
    end
  end

  // ==========================================================
  // interrupt gating
  assign tx_gate = |(tx_pend_reg & txb_en_reg[4:2])
    | |(ptx_pend_reg & buf_en_reg[7:2]);
  assign rx_gate = |(rxd_pend_reg & buf_en_reg[1:0])
    | |(prx_pend_reg & buf_en_reg[7:2]);

  always @*
  begin
    req_vec = flags_reg & enables_reg & mask;
    if (!mode0)
    begin
      // master enable already sits in req_vec; clearing it blocks all
      req_vec[`CIRQ_BIT_TX_GROUP] = req_vec[`CIRQ_BIT_TX_GROUP] & tx_gate;
      req_vec[`CIRQ_BIT_RX_GROUP] = req_vec[`CIRQ_BIT_RX_GROUP] & rx_gate;
    end
  end

  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      irq_high_out <= 1'b0;
      irq_low_out <= 1'b0;
      mode_out <= `CIRQ_RST_MODE;
    end
    else
    begin
      irq_high_out <= |(req_vec & prios_reg);
      irq_low_out <= |(req_vec & ~prios_reg);
      mode_out <= mode_reg;
    end
  end

  // ==========================================================
  // pin control
  // released recessive level leaves the line to the transceiver
  // pull-up, which picks up crosstalk on a differential bus
  always @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      can_transmit_pin_out <= 1'b1;
      can_transmit_pin_oe_out <= 1'b0;
      capture_unit_in_out <= 1'b0;
    end
    else
    begin
      can_transmit_pin_out <= tx_bit_in;
      can_transmit_pin_oe_out <= ~tx_bit_in | pin_ctrl_reg[`CIRQ_BIT_DRIVE_HIGH];
      capture_unit_in_out <= pin_ctrl_reg[`CIRQ_BIT_RX_CAPTURE]
        ? rx_msg_signal_in : capture_pin_level;
    end
  end

endmodule // cirq_top

`default_nettype wire

// [tb/cirq_can_side_model.sv]
// transceiver side: resolves the transmit wire and drives the capture pin
`default_nettype none
module cirq_can_side_model
(
  // from the block
  input wire logic tx_pin_in,
  input wire logic tx_oe_in,
  // capture level commanded by the bench
  input wire logic cap_level_in,
  // wire levels
  output logic bus_level_out,
  output logic capture_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // transceiver input pull-up holds the wire recessive once released
  assign bus_level_out = tx_oe_in ? tx_pin_in : 1'b1;
  assign capture_pin_out = cap_level_in;
endmodule // cirq_can_side_model
`default_nettype wire

// [tb/cirq_chk_assertions.sv]
// concurrent checks on the can event block ports
`default_nettype none
`include "cirq_defs.vh"
module cirq_chk #(
  parameter ADDR_W = 8,
  parameter ERR_SRC_W = 4
)
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wready_out,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic [31:0] s_axi_rdata_out,
  // pins and lines
  input wire logic tx_bit_in,
  input wire logic can_transmit_pin_out,
  input wire logic can_transmit_pin_oe_out,
  input wire logic irq_high_out,
  input wire logic irq_low_out,
  input wire logic [1:0] mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W-1:0] rd_a_reg;
  logic en_seen_reg;
  logic prio_seen_reg;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  // ==========================================================
  // helper state
  // until enables or priorities are written, their reset values alone decide the lines
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_a_reg <= '0;
      en_seen_reg <= 1'b0;
      prio_seen_reg <= 1'b0;
    end
    else
    begin
      if (s_axi_arvalid_in && s_axi_arready_out)
        rd_a_reg <= s_axi_araddr_in;
      if (s_axi_awvalid_in && s_axi_awready_out && s_axi_awaddr_in == `CIRQ_OFS_ENABLES)
        en_seen_reg <= 1'b1;
      if (s_axi_awvalid_in && s_axi_awready_out && s_axi_awaddr_in == `CIRQ_OFS_PRIOS)
        prio_seen_reg <= 1'b1;
    end
  end
  // ==========================================================
  // properties
  sequence s_rd_irq;
    s_axi_rvalid_out && rd_a_reg inside {`CIRQ_OFS_FLAGS, `CIRQ_OFS_ENABLES, `CIRQ_OFS_PRIOS};
  endsequence
  a_dom_drive: assert property (
    !$past(tx_bit_in) && !$past(rst_in) |-> can_transmit_pin_oe_out && !can_transmit_pin_out)
    else $error("dominant bit not driven low");
  a_rec_release: assert property (
    !can_transmit_pin_oe_out |-> can_transmit_pin_out)
    else $error("released pin not recessive");
  a_quiet_unen: assert property (
    !en_seen_reg |-> !irq_high_out && !irq_low_out)
    else $error("request with reset enables");
  a_prio_high: assert property (
    !prio_seen_reg |-> !irq_low_out)
    else $error("low line with reset priorities");
  a_mode_mask: assert property (
    s_rd_irq |-> mode_out == 2'h0 || s_axi_rdata_out[3:2] == 2'h0)
    else $error("buffer bits not zero in modes 1 2");
  a_mode1_low: assert property (
    s_rd_irq ##0 mode_out == 2'h1 |-> !s_axi_rdata_out[0])
    else $error("bit 0 not zero in mode 1");
  a_txb_width: assert property (
    s_axi_rvalid_out && rd_a_reg == `CIRQ_OFS_TXB_EN |-> (s_axi_rdata_out & ~32'h1C) == 32'h0)
    else $error("transmit enable spare bits set");
  a_bufreg_gone: assert property (
    s_axi_rvalid_out && mode_out == 2'h0
    && (rd_a_reg == `CIRQ_OFS_TXB_EN || rd_a_reg == `CIRQ_OFS_BUF_EN) |-> s_axi_rdata_out == 32'h0)
    else $error("buffer enables present in mode 0");
  // address and data are only ever taken as a pair
  a_wr_pair: assert property (
    s_axi_wready_out == s_axi_awready_out)
    else $error("write data ready not paired with address ready");
endmodule // cirq_chk
bind cirq_top cirq_chk #(.ADDR_W(ADDR_W), .ERR_SRC_W(ERR_SRC_W)) u_chk (.*);
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the can event block
`default_nettype none
`include "cirq_defs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_rready_in, tx_bit_in, rx_msg_signal_in, cap_lvl, bus_lvl;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd_q;
  logic [3:0] s_axi_wstrb_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, mode_out, br_q, rr_q;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, can_transmit_pin_out, can_transmit_pin_oe_out, capture_input_pin_in;
  logic capture_unit_in_out, irq_high_out, irq_low_out;
  logic [23:0] evv;
  int errors = 0, checked = 0;
  // rows: mode, address, write data, read back
  logic [31:0] rows [9] = '{32'h0000FF30, 32'h0008FFFF, 32'h0010FF00, 32'h0014FF00,
    32'h0108FFF2, 32'h010CFFF2, 32'h0208FFF3, 32'h0110FF1C, 32'h0214FFFF};
  logic [15:0] rst_rows [7] = '{16'h0000, 16'h0400, 16'h0800, 16'h0CFF, 16'h1000,
    16'h1400, 16'h1800};
  int ev_map [8] = '{0, 1, 3, 8, 7, 6, 22, 21};
  // ==========================================================
  // design and far side
  cirq_top dut (.*, .invalid_msg_evt_in(evv[0]), .bus_wake_evt_in(evv[1]),
    .module_err_evt_in(evv[5:2]), .tx_buf_done_evt_in(evv[8:6]),
    .prog_tx_done_evt_in(evv[14:9]), .prog_rx_full_evt_in(evv[20:15]),
    .rx_buf_full_evt_in(evv[22:21]), .fifo_watermark_evt_in(evv[23]));
  cirq_can_side_model u_side (.tx_pin_in(can_transmit_pin_out),
    .tx_oe_in(can_transmit_pin_oe_out), .cap_level_in(cap_lvl), .bus_level_out(bus_lvl),
    .capture_pin_out(capture_input_pin_in));
  // ==========================================================
  // tasks
  task automatic close_out();
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, e, g);
    end
  endtask
  function automatic logic hs(input int k);
    return k == 0 ? s_axi_awready_out : k == 1 ? s_axi_bvalid_out
      : k == 2 ? s_axi_arready_out : s_axi_rvalid_out;
  endfunction
  // a handshake that never comes counts once and the run goes on
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    do
      @(posedge sys_clk_in);
    while (hs(k) !== 1'b1 && ++n < 50);
    if (n >= 50)
      errors++;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= {24'h0, d};
    s_axi_wstrb_in <= s;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    wait_hi(0);
    s_axi_awvalid_in <= 1'b0;
    s_axi_wvalid_in <= 1'b0;
    wait_hi(1);
    br_q = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    wait_hi(2);
    s_axi_arvalid_in <= 1'b0;
    wait_hi(3);
    rd_q = s_axi_rdata_out;
    rr_q = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask
  task automatic pulse(input int b);
    @(posedge sys_clk_in);
    evv[b] <= 1'b1;
    @(posedge sys_clk_in);
    evv <= '0;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic do_reset();
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    wait_n(6);
    rst_in <= 1'b0;
  endtask
  // ==========================================================
  // clock, watchdog, sequence
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    wait_n(20000);
    errors++;
    close_out();
  end
  initial
  begin
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = '0;
    {s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
    {s_axi_wstrb_in, evv, rx_msg_signal_in, cap_lvl} = '0;
    {rst_in, tx_bit_in} = 2'h3;
    do_reset();
    foreach (rows[i])
    begin
      axi_wr(`CIRQ_OFS_MODE, rows[i][31:24], 4'h1);
      axi_wr(rows[i][23:16], rows[i][15:8], 4'h1);
      chk("write resp", 32'h0, {30'h0, br_q});
      chk("mode line", {24'h0, rows[i][31:24]}, {30'h0, mode_out});
      axi_rd(rows[i][23:16]);
      chk("register", {24'h0, rows[i][7:0]}, rd_q);
    end
    do_reset();
    foreach (rst_rows[i])
    begin
      axi_rd(rst_rows[i][15:8]);
      chk("reset value", {24'h0, rst_rows[i][7:0]}, rd_q);
    end
    axi_wr(`CIRQ_OFS_ENABLES, 8'hFF, 4'h1);
    foreach (ev_map[i])
    begin
      pulse(ev_map[i]);
      axi_rd(`CIRQ_OFS_FLAGS);
      chk("flags", 32'h80 >> i, rd_q);
      chk("irq lines", 32'h2, {30'h0, irq_high_out, irq_low_out});
      axi_wr(`CIRQ_OFS_FLAGS, 8'h00, 4'h1);
    end
    axi_wr(`CIRQ_OFS_PRIOS, 8'h7F, 4'h1);
    pulse(0);
    wait_n(3);
    chk("low line", 32'h1, {30'h0, irq_high_out, irq_low_out});
    axi_wr(`CIRQ_OFS_FLAGS, 8'h00, 4'h1);
    axi_wr(`CIRQ_OFS_MODE, 8'h01, 4'h1);
    axi_wr(`CIRQ_OFS_ENABLES, 8'h12, 4'h1);
    pulse(6);
    axi_rd(`CIRQ_OFS_FLAGS);
    chk("tx group flag", 32'h10, rd_q);
    chk("tx buffer gate", 32'h0, {31'h0, irq_high_out});
    axi_wr(`CIRQ_OFS_TXB_EN, 8'h04, 4'h1);
    wait_n(2);
    chk("tx buffer on", 32'h1, {31'h0, irq_high_out});
    axi_wr(`CIRQ_OFS_ENABLES, 8'h02, 4'h1);
    wait_n(2);
    chk("tx master off", 32'h0, {31'h0, irq_high_out});
    axi_wr(`CIRQ_OFS_FLAGS, 8'h00, 4'h1);
    axi_wr(`CIRQ_OFS_BUF_EN, 8'h04, 4'h1);
    pulse(15);
    pulse(23);
    axi_rd(`CIRQ_OFS_FLAGS);
    chk("rx group flag", 32'h02, rd_q);
    chk("rx master on", 32'h1, {31'h0, irq_high_out});
    axi_wr(`CIRQ_OFS_FLAGS, 8'h00, 4'h1);
    axi_wr(`CIRQ_OFS_ENABLES, 8'h10, 4'h1);
    pulse(9);
    wait_n(2);
    chk("prog tx on", 32'h1, {31'h0, irq_high_out});
    axi_wr(`CIRQ_OFS_MODE, 8'h02, 4'h1);
    axi_wr(`CIRQ_OFS_FLAGS, 8'h00, 4'h1);
    pulse(23);
    axi_rd(`CIRQ_OFS_FLAGS);
    chk("watermark flag", 32'h01, rd_q);
    tx_bit_in <= 1'b0;
    wait_n(2);
    chk("dominant", 32'h4, {29'h0, can_transmit_pin_oe_out, can_transmit_pin_out, bus_lvl});
    tx_bit_in <= 1'b1;
    wait_n(2);
    chk("released", 32'h3, {29'h0, can_transmit_pin_oe_out, can_transmit_pin_out, bus_lvl});
    axi_wr(`CIRQ_OFS_PIN_CTRL, 8'h30, 4'h1);
    rx_msg_signal_in <= 1'b1;
    wait_n(2);
    chk("drive high", 32'h7, {29'h0, can_transmit_pin_oe_out, can_transmit_pin_out, bus_lvl});
    chk("capture routed", 32'h1, {31'h0, capture_unit_in_out});
    axi_wr(`CIRQ_OFS_PIN_CTRL, 8'h20, 4'h1);
    wait_n(6);
    chk("capture pin low", 32'h0, {31'h0, capture_unit_in_out});
    cap_lvl <= 1'b1;
    wait_n(6);
    chk("capture pin high", 32'h1, {31'h0, capture_unit_in_out});
    axi_wr(`CIRQ_OFS_PRIOS, 8'h00, 4'h2);
    axi_rd(`CIRQ_OFS_PRIOS);
    chk("lane 0 off", 32'h73, rd_q);
    axi_wr(8'h1C, 8'hFF, 4'h1);
    axi_rd(8'h1C);
    chk("unmapped", 32'hA0, {24'h0, br_q, rr_q, rd_q[3:0]});
    close_out();
  end
endmodule // tb
`default_nettype wire
